/* File: cifa_pkg.sv */
// What this block does
// - Set nibble carry on carry out of the low four result bits.
// - Set result nil flag when the result is zero, else clear it.
// - Copy result bit seven into the msb set flag.
// - Masked sources stay pending; allow bit one lets them interrupt.
// - Reset clears allow bit; only an instruction sets it again.
// - Allow bit clears after counter stacked and vector fetched.
// - Instruction in progress finishes before entry starts.
// - Entry pushes counter, jumps to own vector, takes five cycles.
// - Trap return pops in reverse order, sets allow bit, resumes.
// - Four sources: three gated by allow bit, soft trap never.
// - Soft trap always interrupts using the same entry sequence.
// - Priority: wakeup, timer 0, timer 1, soft trap lowest.
// - Indexed address is 8-bit offset plus low ten base bits.
// - Direct mode uses 8-bit field as data memory pointer.
// - Immediate mode uses the 8-bit field as operand value.
// - Inherent instructions fetch no operand bytes.
// - Absolute 10-bit address in two bytes, long branch and call only.
// - Short branch target relative, displacement -31 to +32.
// - Software may set allow bit inside a service routine.
// - Push subtracts two from stack index, pop adds two.
// - Low byte of a return address is written first.
// - Base bit 10 selects data 0x000-0x0ff or program 0xc00-0xfff.
package cifa_pkg;
    // ----------------------------------------------------------------
    // Widths and fixed addresses
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int PC_W = 10;
    localparam int SRC_N = 4;
    localparam logic [ADDR_W-1:0] VEC_TIMER0 = 12'hff6;
    localparam logic [ADDR_W-1:0] VEC_TIMER1 = 12'hff8;
    localparam logic [ADDR_W-1:0] VEC_WAKEUP = 12'hffa;
    localparam logic [ADDR_W-1:0] VEC_SOFT = 12'hffc;
    localparam logic [ADDR_W-1:0] PROG_BASE = 12'hc00;
    localparam logic [ADDR_W-1:0] STACK_BASE = 12'h030;
    localparam logic [3:0] STACK_RESET = 4'hf;
    localparam logic [3:0] STACK_STEP = 4'h2;
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;
    localparam int ENTRY_CYCLES = 5;
    localparam int BASE_SEL_BIT = 10;
    localparam logic signed [7:0] REL_MIN = -8'sd31;
    localparam logic signed [7:0] REL_MAX = 8'sd32;
    // Source indices, highest priority first
    localparam int SRC_WAKEUP = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_TIMER1 = 2;
    localparam int SRC_SOFT = 3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CIFA_MODE_INHERENT = 3'h0,
        CIFA_MODE_IMMEDIATE = 3'h1,
        CIFA_MODE_DIRECT = 3'h2,
        CIFA_MODE_INDEXED = 3'h3,
        CIFA_MODE_ABSOLUTE = 3'h4,
        CIFA_MODE_RELATIVE = 3'h5
    } cifa_mode_t;

    typedef struct packed {
        logic nibbleCarry;
        logic resultNil;
        logic msbSet;
        logic allow;
    } cifa_flags_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } cifa_mem_t;
endpackage : cifa_pkg

/* File: cifa_addr_gen.sv */
module cifa_addr_gen (
    input wire logic ref_clk,
    input wire logic rst_n,
    input cifa_pkg::cifa_mode_t mode,
    input wire logic [7:0] opByte1,
    input wire logic [7:0] opByte2,
    input wire logic [10:0] offsetBase,
    input wire logic [cifa_pkg::PC_W-1:0] fetchCounter,
    input wire logic isLongOp,
    output logic [cifa_pkg::ADDR_W-1:0] effAddr,
    output logic [7:0] operand,
    output logic [1:0] operandBytes,
    output logic modeError
);
    logic [9:0] idxSum;
    logic signed [7:0] disp;
    logic relOk;

    assign idxSum = offsetBase[9:0] + {2'h0, opByte1};
    assign disp = $signed(opByte1);
    assign relOk = (disp >= cifa_pkg::REL_MIN) && (disp <= cifa_pkg::REL_MAX);

    // ----------------------------------------------------------------
    // Registered address forming
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            effAddr <= 12'h000;
            operand <= 8'h00;
            operandBytes <= 2'h0;
            modeError <= 1'b0;
        end else begin
            modeError <= 1'b0;
            operand <= 8'h00;
            case (mode)
                cifa_pkg::CIFA_MODE_INHERENT: begin
                    operandBytes <= 2'h0;
                    effAddr <= 12'h000;
                end
                cifa_pkg::CIFA_MODE_IMMEDIATE: begin
                    operandBytes <= 2'h1;
                    operand <= opByte1;
                    effAddr <= 12'h000;
                end
                cifa_pkg::CIFA_MODE_DIRECT: begin
                    operandBytes <= 2'h1;
                    effAddr <= {4'h0, opByte1};
                end
                cifa_pkg::CIFA_MODE_INDEXED: begin
                    operandBytes <= 2'h1;
                    // Space select bit kept separate from the sum
                    if (offsetBase[cifa_pkg::BASE_SEL_BIT]) begin
                        effAddr <= cifa_pkg::PROG_BASE | {2'h0, idxSum};
                    end else begin
                        effAddr <= {4'h0, idxSum[7:0]};
                    end
                end
                cifa_pkg::CIFA_MODE_ABSOLUTE: begin
                    operandBytes <= 2'h2;
                    effAddr <= cifa_pkg::PROG_BASE
                        | {2'h0, opByte1[1:0], opByte2};
                    modeError <= !isLongOp;
                end
                cifa_pkg::CIFA_MODE_RELATIVE: begin
                    operandBytes <= 2'h1;
                    effAddr <= cifa_pkg::PROG_BASE | {2'h0,
                        fetchCounter + 10'(signed'(disp))};
                    modeError <= !relOk;
                end
                default: begin
                    operandBytes <= 2'h0;
                    effAddr <= 12'h000;
                    modeError <= 1'b1;
                end
            endcase
        end
    end
endmodule : cifa_addr_gen

/* File: cifa_flag_unit.sv */
module cifa_flag_unit (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic resultValid,
    input wire logic [7:0] resultValue,
    input wire logic nibbleCarryIn,
    output logic nibbleCarry,
    output logic resultNil,
    output logic msbSet
);
    // ----------------------------------------------------------------
    // Condition flags
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            nibbleCarry <= 1'b0;
            resultNil <= 1'b0;
            msbSet <= 1'b0;
        end else if (resultValid) begin
            nibbleCarry <= nibbleCarryIn;
            resultNil <= (resultValue == 8'h00);
            msbSet <= resultValue[7];
        end
    end

    AST_NIL_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
        resultValid |=> resultNil == ($past(resultValue) == 8'h00))
        else $error("nil flag mismatch");
    AST_MSB_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
        resultValid |=> msbSet == $past(resultValue[7]))
        else $error("msb flag mismatch");
    AST_HOLD_FLAGS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !resultValid |=> $stable(resultNil) && $stable(msbSet)
        && $stable(nibbleCarry))
        else $error("flags changed without result");
endmodule : cifa_flag_unit

/* File: cifa_core_soft_trap_op.sv */
// The address-and-strobe port and the address map were left to the implementer.
module cifa_core_soft_trap_op #(
    parameter int ENTRY_LEN = cifa_pkg::ENTRY_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    // Execution side
    input wire logic instrDone,
    input wire logic softTrapOp,
    input wire logic trapReturnOp,
    input wire logic callExitOp,
    input wire logic setAllowOp,
    input wire logic clearAllowOp,
    input wire logic [cifa_pkg::PC_W-1:0] fetchCounter,
    // Flag inputs from the arithmetic unit
    input wire logic resultValid,
    input wire logic [7:0] resultValue,
    input wire logic nibbleCarryIn,
    // Addressing inputs
    input cifa_pkg::cifa_mode_t mode,
    input wire logic [7:0] opByte1,
    input wire logic [7:0] opByte2,
    input wire logic [10:0] offsetBase,
    input wire logic isLongOp,
    // Peripheral sources
    input wire logic wakeupIrq,
    input wire logic timer0Irq,
    input wire logic timer1Irq,
    // Program and data memory
    input wire logic [7:0] memRdata,
    output cifa_pkg::cifa_mem_t memReq,
    // Results
    output cifa_pkg::cifa_flags_t flagsWord,
    output logic [3:0] stackTopIndex,
    output logic [cifa_pkg::PC_W-1:0] resumeAddr,
    output logic resumeValid,
    output logic entryBusy,
    output logic [cifa_pkg::SRC_N-1:0] pendingSources,
    output logic [cifa_pkg::ADDR_W-1:0] effAddr,
    output logic [7:0] operand,
    output logic [1:0] operandBytes,
    output logic modeError
);
    if (ENTRY_LEN != cifa_pkg::ENTRY_CYCLES) begin : gBadEntryLen
        $error("entry length must equal five cycles");
    end

    typedef enum logic [2:0] {
        CIFA_ST_RUN = 3'h0,
        CIFA_ST_PUSH_LO = 3'h1,
        CIFA_ST_PUSH_HI = 3'h2,
        CIFA_ST_VEC_LO = 3'h3,
        CIFA_ST_VEC_HI = 3'h4,
        CIFA_ST_JUMP = 3'h5,
        CIFA_ST_POP_LO = 3'h6,
        CIFA_ST_POP_HI = 3'h7
    } cifa_state_t;

    cifa_state_t state;
    logic allow;
    logic [cifa_pkg::SRC_N-1:0] softPend;
    logic [cifa_pkg::SRC_N-1:0] eligible;
    logic [cifa_pkg::SRC_N-1:0] grant;
    logic [cifa_pkg::ADDR_W-1:0] vecAddr;
    logic [cifa_pkg::ADDR_W-1:0] chosenVec;
    logic [cifa_pkg::PC_W-1:0] savedPc;
    logic [7:0] vecLo;
    logic [1:0] popHi;
    logic popTail;
    logic popWithAllow;
    logic [2:0] entryCount;
    logic nibC;
    logic nilF;
    logic msbF;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    cifa_flag_unit flagUnit (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .resultValid(resultValid),
        .resultValue(resultValue),
        .nibbleCarryIn(nibbleCarryIn),
        .nibbleCarry(nibC),
        .resultNil(nilF),
        .msbSet(msbF)
    );

    cifa_addr_gen addrGen (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .mode(mode),
        .opByte1(opByte1),
        .opByte2(opByte2),
        .offsetBase(offsetBase),
        .fetchCounter(fetchCounter),
        .isLongOp(isLongOp),
        .effAddr(effAddr),
        .operand(operand),
        .operandBytes(operandBytes),
        .modeError(modeError)
    );

    assign flagsWord = '{nibbleCarry: nibC, resultNil: nilF,
                         msbSet: msbF, allow: allow};

    // ----------------------------------------------------------------
    // Pending and priority
    // ----------------------------------------------------------------
    // Peripheral levels are held by their sources until cleared
    assign pendingSources = {softPend[cifa_pkg::SRC_SOFT], timer1Irq,
                             timer0Irq, wakeupIrq};
    // Bit order: 0 wakeup .. 3 soft, same order as pendingSources
    always_comb begin
        eligible = '0;
        eligible[cifa_pkg::SRC_WAKEUP] = wakeupIrq && allow;
        eligible[cifa_pkg::SRC_TIMER0] = timer0Irq && allow;
        eligible[cifa_pkg::SRC_TIMER1] = timer1Irq && allow;
        eligible[cifa_pkg::SRC_SOFT] = softPend[cifa_pkg::SRC_SOFT];
    end

    // Lowest index wins, one source per entry
    always_comb begin
        grant = '0;
        vecAddr = cifa_pkg::VEC_SOFT;
        if (eligible[cifa_pkg::SRC_WAKEUP]) begin
            grant[cifa_pkg::SRC_WAKEUP] = 1'b1;
            vecAddr = cifa_pkg::VEC_WAKEUP;
        end else if (eligible[cifa_pkg::SRC_TIMER0]) begin
            grant[cifa_pkg::SRC_TIMER0] = 1'b1;
            vecAddr = cifa_pkg::VEC_TIMER0;
        end else if (eligible[cifa_pkg::SRC_TIMER1]) begin
            grant[cifa_pkg::SRC_TIMER1] = 1'b1;
            vecAddr = cifa_pkg::VEC_TIMER1;
        end else if (eligible[cifa_pkg::SRC_SOFT]) begin
            grant[cifa_pkg::SRC_SOFT] = 1'b1;
            vecAddr = cifa_pkg::VEC_SOFT;
        end
    end

    // ----------------------------------------------------------------
    // Soft trap latch
    // ----------------------------------------------------------------
    // Set wins over the grant clear so a new trap is never lost
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            softPend <= '0;
        end else if (softTrapOp) begin
            softPend[cifa_pkg::SRC_SOFT] <= 1'b1;
        end else if (state == CIFA_ST_RUN && instrDone
                     && grant[cifa_pkg::SRC_SOFT]) begin
            softPend[cifa_pkg::SRC_SOFT] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Entry and return sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= CIFA_ST_RUN;
            chosenVec <= 12'h000;
            savedPc <= cifa_pkg::PC_RESET;
            vecLo <= 8'h00;
            popHi <= 2'h0;
            popWithAllow <= 1'b0;
            popTail <= 1'b0;
        end else begin
            // Low byte lands one cycle after its read, past the last state
            popTail <= (state == CIFA_ST_POP_HI);
            case (state)
                CIFA_ST_RUN: begin
                    // Only at an instruction boundary
                    if (instrDone && |grant) begin
                        state <= CIFA_ST_PUSH_LO;
                        chosenVec <= vecAddr;
                        savedPc <= fetchCounter;
                    end else if (instrDone && (trapReturnOp || callExitOp)) begin
                        state <= CIFA_ST_POP_LO;
                        popWithAllow <= trapReturnOp;
                    end
                end
                CIFA_ST_PUSH_LO: state <= CIFA_ST_PUSH_HI;
                CIFA_ST_PUSH_HI: state <= CIFA_ST_VEC_LO;
                CIFA_ST_VEC_LO: state <= CIFA_ST_VEC_HI;
                CIFA_ST_VEC_HI: begin
                    vecLo <= memRdata;
                    state <= CIFA_ST_JUMP;
                end
                CIFA_ST_JUMP: state <= CIFA_ST_RUN;
                CIFA_ST_POP_LO: state <= CIFA_ST_POP_HI;
                CIFA_ST_POP_HI: begin
                    popHi <= memRdata[1:0];
                    state <= CIFA_ST_RUN;
                end
                default: state <= CIFA_ST_RUN;
            endcase
        end
    end

    // Five cycle counter across the entry, checked below
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            entryCount <= 3'h0;
        end else if (state == CIFA_ST_RUN) begin
            entryCount <= 3'h0;
        end else if (entryBusy) begin
            entryCount <= entryCount + 3'h1;
        end
    end

    assign entryBusy = (state == CIFA_ST_PUSH_LO) || (state == CIFA_ST_PUSH_HI)
        || (state == CIFA_ST_VEC_LO) || (state == CIFA_ST_VEC_HI)
        || (state == CIFA_ST_JUMP);

    // ----------------------------------------------------------------
    // Stack index
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stackTopIndex <= cifa_pkg::STACK_RESET;
        end else if (state == CIFA_ST_PUSH_HI) begin
            stackTopIndex <= stackTopIndex - cifa_pkg::STACK_STEP;
        end else if (state == CIFA_ST_POP_HI) begin
            stackTopIndex <= stackTopIndex + cifa_pkg::STACK_STEP;
        end
    end

    // ----------------------------------------------------------------
    // Memory requests
    // ----------------------------------------------------------------
    // Index points at the next free byte; a pushed pair sits just above it
    always_comb begin
        memReq = '0;
        case (state)
            CIFA_ST_PUSH_LO: begin
                memReq.addr = cifa_pkg::STACK_BASE | {8'h00, stackTopIndex};
                memReq.wdata = savedPc[7:0];
                memReq.write = 1'b1;
            end
            CIFA_ST_PUSH_HI: begin
                memReq.addr = cifa_pkg::STACK_BASE
                    | {8'h00, 4'(stackTopIndex - 4'h1)};
                memReq.wdata = {6'h00, savedPc[9:8]};
                memReq.write = 1'b1;
            end
            CIFA_ST_VEC_LO: begin
                memReq.addr = chosenVec;
                memReq.read = 1'b1;
            end
            CIFA_ST_VEC_HI: begin
                memReq.addr = chosenVec + 12'h001;
                memReq.read = 1'b1;
            end
            // Reverse order: high byte first, low byte last
            CIFA_ST_POP_LO: begin
                memReq.addr = cifa_pkg::STACK_BASE
                    | {8'h00, 4'(stackTopIndex + 4'h1)};
                memReq.read = 1'b1;
            end
            CIFA_ST_POP_HI: begin
                memReq.addr = cifa_pkg::STACK_BASE
                    | {8'h00, 4'(stackTopIndex + 4'h2)};
                memReq.read = 1'b1;
            end
            default: memReq = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // Resume target
    // ----------------------------------------------------------------
    // Read data arrives one cycle after each read request
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            resumeAddr <= cifa_pkg::PC_RESET;
            resumeValid <= 1'b0;
        end else begin
            resumeValid <= 1'b0;
            if (state == CIFA_ST_JUMP) begin
                resumeAddr <= {memRdata[1:0], vecLo};
                resumeValid <= 1'b1;
            end else if (popTail) begin
                resumeAddr <= {popHi, memRdata};
                resumeValid <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Global allow bit
    // ----------------------------------------------------------------
    // Cleared late so the vector read cannot be preempted
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            allow <= 1'b0;
        end else if (state == CIFA_ST_JUMP) begin
            allow <= 1'b0;
        end else if (popTail && popWithAllow) begin
            allow <= 1'b1;
        end else if (setAllowOp) begin
            allow <= 1'b1;
        end else if (clearAllowOp) begin
            allow <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_ENTRY_FIVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == CIFA_ST_PUSH_LO |-> entryBusy [*5] ##1 !entryBusy)
        else $error("entry not five cycles");
    AST_ENTRY_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == CIFA_ST_JUMP |-> entryCount == 3'(ENTRY_LEN - 1))
        else $error("entry count wrong");
    AST_ALLOW_LATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == CIFA_ST_PUSH_LO && allow |-> ##1 allow ##1 allow ##1 allow
        ##1 allow ##1 !allow)
        else $error("allow cleared too early");
    AST_MASKED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == CIFA_ST_RUN && !allow && !softPend[cifa_pkg::SRC_SOFT]
        |=> state != CIFA_ST_PUSH_LO)
        else $error("masked source interrupted");
    AST_BOUNDARY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == CIFA_ST_RUN && !instrDone |=> state == CIFA_ST_RUN)
        else $error("entry without boundary");
    AST_SOFT_ALWAYS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == CIFA_ST_RUN && instrDone && !allow
        && softPend[cifa_pkg::SRC_SOFT]
        |=> state == CIFA_ST_PUSH_LO)
        else $error("soft trap lost");
    AST_PRIO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == CIFA_ST_RUN && instrDone && allow && wakeupIrq
        |=> chosenVec == cifa_pkg::VEC_WAKEUP)
        else $error("priority wrong");
    AST_LOW_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == CIFA_ST_PUSH_LO |-> memReq.wdata == savedPc[7:0]
        ##1 memReq.wdata[1:0] == savedPc[9:8])
        else $error("push order wrong");
    AST_STACK_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == CIFA_ST_PUSH_HI |=> stackTopIndex
        == 4'($past(stackTopIndex) - 4'h2))
        else $error("stack step wrong");
    AST_TRAP_RETURN_OP_ALLOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == CIFA_ST_POP_HI && popWithAllow |=> ##1 allow
        && resumeValid)
        else $error("trap return did not allow");
endmodule : cifa_core_soft_trap_op

/* File: cifa_mem_model.sv */
module cifa_mem_model (
    input wire logic ref_clk,
    input cifa_pkg::cifa_mem_t memReq,
    output logic [7:0] memRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // Program and data memory
    // ----------------------------------------------------------------
    logic [7:0] mem [0:4095];
    initial begin
        memRdata = 8'h00;
        // Two-byte vectors, low byte at lower address
        mem[cifa_pkg::VEC_WAKEUP] = 8'h11;
        mem[cifa_pkg::VEC_WAKEUP + 1] = 8'h02;
        mem[cifa_pkg::VEC_TIMER0] = 8'h22;
        mem[cifa_pkg::VEC_TIMER0 + 1] = 8'h01;
        mem[cifa_pkg::VEC_TIMER1] = 8'h44;
        mem[cifa_pkg::VEC_TIMER1 + 1] = 8'h00;
        mem[cifa_pkg::VEC_SOFT] = 8'h33;
        mem[cifa_pkg::VEC_SOFT + 1] = 8'h03;
    end
    // Idle cycles flip the bus so stale data never looks valid
    always @(posedge ref_clk) begin
        if (memReq.write) begin
            mem[memReq.addr] <= memReq.wdata;
        end
        memRdata <= memReq.read ? mem[memReq.addr] : ~memRdata;
    end
endmodule : cifa_mem_model

/* File: core_interrupt_flag_addressing_tb.sv */
module core_interrupt_flag_addressing_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, rst_n, instrDone, softTrapOp, trapReturnOp, setAllowOp;
    logic resultValid, nibbleCarryIn, isLongOp, wakeupIrq, timer0Irq;
    logic timer1Irq, resumeValid, entryBusy, modeError;
    logic [9:0] fetchCounter, resumeAddr;
    logic [7:0] resultValue, opByte1, opByte2, memRdata, operand;
    logic [1:0] operandBytes;
    logic [10:0] offsetBase;
    logic [11:0] effAddr;
    logic [3:0] stackTopIndex, pendingSources;
    cifa_pkg::cifa_mode_t mode;
    cifa_pkg::cifa_mem_t memReq;
    cifa_pkg::cifa_flags_t flagsWord;
    int errTotal = 0;
    int nCompared = 0;
    cifa_core_soft_trap_op i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .instrDone(instrDone), .softTrapOp(softTrapOp),
        .trapReturnOp(trapReturnOp), .callExitOp(1'b0),
        .setAllowOp(setAllowOp), .clearAllowOp(1'b0),
        .fetchCounter(fetchCounter), .resultValid(resultValid),
        .resultValue(resultValue), .nibbleCarryIn(nibbleCarryIn),
        .mode(mode), .opByte1(opByte1), .opByte2(opByte2),
        .offsetBase(offsetBase), .isLongOp(isLongOp), .wakeupIrq(wakeupIrq),
        .timer0Irq(timer0Irq), .timer1Irq(timer1Irq), .memRdata(memRdata),
        .memReq(memReq), .flagsWord(flagsWord),
        .stackTopIndex(stackTopIndex), .resumeAddr(resumeAddr),
        .resumeValid(resumeValid), .entryBusy(entryBusy),
        .pendingSources(pendingSources), .effAddr(effAddr),
        .operand(operand), .operandBytes(operandBytes), .modeError(modeError));
    cifa_mem_model i_mem (.ref_clk(ref_clk), .memReq(memReq),
        .memRdata(memRdata));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task testDone();
        if (errTotal == 0 && nCompared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : testDone
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errTotal++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Ops {soft trap, trap return, set allow, instruction done}
    task op(input logic [3:0] ops);
        @(posedge ref_clk);
        {softTrapOp, trapReturnOp, setAllowOp, instrDone} <= ops;
        @(posedge ref_clk);
        {softTrapOp, trapReturnOp, setAllowOp, instrDone} <= 4'h0;
        #1;
    endtask : op
    task waitResume(input logic [9:0] exp);
        int i;
        for (i = 0; i < 20 && resumeValid !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (i == 20) begin
            errTotal++;
            testDone();
        end else chk(resumeAddr, exp);
    endtask : waitResume
    task addr(input cifa_pkg::cifa_mode_t m, input logic [10:0] b,
              input logic [7:0] o, input logic l);
        @(posedge ref_clk);
        mode <= m;
        {offsetBase, opByte1, isLongOp} <= {b, o, l};
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : addr
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_n, instrDone, softTrapOp, trapReturnOp, setAllowOp} = 5'h00;
        {resultValid, nibbleCarryIn, isLongOp, resultValue, opByte1} = '0;
        opByte2 = 8'h00;
        {wakeupIrq, timer0Irq, timer1Irq, offsetBase} = '0;
        mode = cifa_pkg::CIFA_MODE_INHERENT;
        fetchCounter = 10'h155;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk(flagsWord.allow, 1'b0);
        chk(stackTopIndex, 4'hf);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            resultValid <= 1'b1;
            resultValue <= 8'(i << 6);
            nibbleCarryIn <= i[0];
            @(posedge ref_clk);
            resultValid <= 1'b0;
            #1;
            chk(flagsWord.resultNil, i == 0);
            chk(flagsWord.msbSet, i == 2);
            chk(flagsWord.nibbleCarry, i[0]);
        end
        wakeupIrq <= 1'b1;
        op(4'h1);
        chk(entryBusy, 1'b0);
        chk(pendingSources, 4'h1);
        op(4'h2);
        op(4'h1);
        waitResume(10'h211);
        wakeupIrq <= 1'b0;
        chk(flagsWord.allow, 1'b0);
        chk(stackTopIndex, 4'hd);
        chk(i_mem.mem[12'h03f], 8'h55);
        chk(i_mem.mem[12'h03e], 8'h01);
        {timer0Irq, timer1Irq, fetchCounter} <= {2'b11, 10'h2aa};
        op(4'h2);
        op(4'h9);
        waitResume(10'h122);
        timer0Irq <= 1'b0;
        op(4'h1);
        waitResume(10'h333);
        op(4'h5);
        waitResume(10'h2aa);
        chk(flagsWord.allow, 1'b1);
        op(4'h1);
        waitResume(10'h044);
        addr(cifa_pkg::CIFA_MODE_INDEXED, 11'h405, 8'h10, 1'b0);
        chk(effAddr, 12'hc15);
        addr(cifa_pkg::CIFA_MODE_INDEXED, 11'h005, 8'h10, 1'b0);
        chk(effAddr, 12'h015);
        addr(cifa_pkg::CIFA_MODE_IMMEDIATE, 11'h005, 8'h5a, 1'b0);
        chk(operand, 8'h5a);
        addr(cifa_pkg::CIFA_MODE_DIRECT, 11'h005, 8'h3c, 1'b0);
        chk(effAddr, 12'h03c);
        addr(cifa_pkg::CIFA_MODE_RELATIVE, 11'h005, 8'he1, 1'b0);
        chk(effAddr, 12'he8b);
        chk(modeError, 1'b0);
        addr(cifa_pkg::CIFA_MODE_INHERENT, 11'h005, 8'h00, 1'b0);
        chk(operandBytes, 2'h0);
        opByte2 <= 8'h34;
        addr(cifa_pkg::CIFA_MODE_ABSOLUTE, 11'h005, 8'h01, 1'b0);
        chk(modeError, 1'b1);
        chk(effAddr, 12'hd34);
        chk(operandBytes, 2'h2);
        testDone();
    end
endmodule : core_interrupt_flag_addressing_tb
